/* verilog/dim_pkg.sv */
// Shared constants, register map and carrier types of the dimming engine.
// Assumes a single 10 MHz clock and a synchronous active-low reset.
`default_nettype none
package dim_pkg;
  // Clock and sampling grid
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMPLE_NS = 10_000;
  localparam int TICK_CYCLES = SAMPLE_NS / (1_000_000_000 / CLK_HZ);
  localparam int TICK_W = 8;
  // Detection and fallback timer times, converted to sample ticks
  localparam int FULL_ON_NS = 40_000_000;
  localparam int FULL_OFF_NS = 2_000_000;
  localparam int FALLBACK_HZ = 500;
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] FULL_ON_TICKS = CNT_W'(FULL_ON_NS / SAMPLE_NS);
  localparam logic [CNT_W-1:0] FULL_OFF_TICKS =
    CNT_W'(FULL_OFF_NS / SAMPLE_NS);
  localparam logic [CNT_W-1:0] FALLBACK_TICKS =
    CNT_W'(1_000_000_000 / (FALLBACK_HZ * SAMPLE_NS));
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  // Duty factor arithmetic
  localparam logic [7:0] DUTY_FULL_CODE = 8'hff;
  localparam logic [8:0] DRF_UNITY = 9'h100;
  localparam int DRF_SHIFT = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DUTY0 = 8'h04;
  localparam logic [7:0] OFF_DUTY1 = 8'h08;
  localparam logic [7:0] OFF_PEAK = 8'h0c;
  localparam logic [7:0] OFF_STATE = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // Field positions
  localparam int CTRL_DFF_LSB = 0;
  localparam int CTRL_DERATE_DIS = 4;
  localparam int PEAK1_LSB = 8;
  localparam int IRQ_W = 4;
  localparam int IRQ_OCP0 = 0;
  localparam int IRQ_OCP1 = 1;
  localparam int IRQ_THERM = 2;
  localparam int IRQ_FULLON = 3;
  // Reset values
  localparam logic [1:0] DFF_RESET = 2'h0;
  localparam logic [6:0] PEAK_RESET = 7'h00;
  localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One measured input period, in sample ticks
  typedef struct packed {
    logic valid;
    logic full_on;
    logic full_off;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] high;
  } dim_meas_type;
endpackage : dim_pkg
`default_nettype wire

/* verilog/dim_input_sampler.sv */
// Samples one dimming input on the 10 us grid and measures its period.
// Assumes the input is synchronous to aclk and tick is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module dim_input_sampler
  import dim_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic tick, // 10 us sample strobe
  input wire logic dimming_input, // Dimming PWM input
  output dim_meas_type meas // Latest measurement
);
  logic prev;
  logic seen_rise;
  logic was_full_on;
  logic [CNT_W-1:0] since_rise;
  logic [CNT_W-1:0] high_cnt;
  logic [CNT_W-1:0] run;
  wire rise = tick & dimming_input & ~prev;
  wire edge_seen = tick & (dimming_input ^ prev);
  wire [CNT_W-1:0] run_inc = (run == CNT_MAX) ? run : run + 1'b1;
  wire long_high = dimming_input & (run > FULL_ON_TICKS);
  wire long_low = ~dimming_input & ((was_full_on & (run >= FULL_OFF_TICKS))
                  | (run > FULL_ON_TICKS));

  // Rise-to-rise period and high time; a period is only reported after two
  // rises so a half-seen period never reaches the output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b0;
      seen_rise <= 1'b0;
      since_rise <= '0;
      high_cnt <= '0;
      run <= '0;
      meas <= '0;
    end else if (tick) begin
      prev <= dimming_input;
      run <= edge_seen ? CNT_W'(1) : run_inc;
      if (rise) begin
        seen_rise <= 1'b1;
        since_rise <= CNT_W'(1);
        high_cnt <= CNT_W'(1);
        meas.valid <= seen_rise;
        meas.period <= since_rise;
        meas.high <= high_cnt;
      end else begin
        since_rise <= (since_rise == CNT_MAX) ? since_rise : since_rise + 1'b1;
        high_cnt <= high_cnt + CNT_W'(dimming_input & (high_cnt != CNT_MAX));
      end
      meas.full_on <= long_high;
      meas.full_off <= long_low;
    end
  end

  // Remembers a full-on spell so the quick 0% detection can apply
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      was_full_on <= 1'b0;
    end else if (tick) begin
      if (long_high) begin
        was_full_on <= 1'b1;
      end else if (rise) begin
        was_full_on <= 1'b0;
      end
    end
  end
endmodule // dim_input_sampler
`default_nettype wire

/* verilog/dim_pwm_rebuilder.sv */
// Rebuilds one buck switch enable waveform on the 10 us grid.
// Assumes period and on time are in ticks; both are taken at period ends.
`timescale 1ns/10ps
`default_nettype none
module dim_pwm_rebuilder
  import dim_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic tick, // 10 us sample strobe
  input wire logic [CNT_W-1:0] period, // Wanted output period
  input wire logic [CNT_W-1:0] on_time, // Wanted on time
  input wire logic kill, // Overcurrent, ends this pulse
  output logic enable // Buck switch enable
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] cur_period;
  logic [CNT_W-1:0] cur_on;
  logic killed;
  wire wrap = (cnt + 1'b1) >= cur_period;
  wire [CNT_W-1:0] next_cnt = wrap ? '0 : cnt + 1'b1;

  // New settings load only at a period boundary so no pulse is cut short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
      cur_period <= '0;
      cur_on <= '0;
      killed <= 1'b0;
    end else begin
      if (tick) begin
        cnt <= next_cnt;
        if (wrap) begin
          cur_period <= period;
          cur_on <= on_time;
          killed <= 1'b0;
        end
      end
      if (kill) begin
        killed <= 1'b1;
      end
    end
  end

  // Registered output; held low in reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= 1'b0;
    end else begin
      enable <= (cnt < cur_on) & ~killed & ~kill;
    end
  end
endmodule // dim_pwm_rebuilder
`default_nettype wire

/* verilog/led_pwm_dimming_engine.sv */
// Two-channel PWM dimming engine with AXI4-Lite registers and interrupt.
// Assumes all inputs are synchronous to aclk; the thermal warning, battery
// derating factor and overcurrent comparators come from analog monitors.
//
// Function
// - Each channel samples its dimming input and rebuilds a buck switch enable.
// - Output frequency equals input frequency times the frequency multiplier.
// - Output duty equals input duty times channel duty factor times derating.
// - Derating is set automatically and applied to both channels together.
// - Per-channel duty factor 0-100%, default at start, writable at runtime.
// - Duty factor is (255 minus code) over 255.
// - A new input frequency yields valid output within four input periods.
// - A duty-only change yields valid output within two input periods.
// - Full-on is seen only after input stays high over 40 ms.
// - Full-on input with scaling below unity dims from 500 Hz times multiplier.
// - Duty code 255 keeps the string off always.
// - Input sampling and output rebuild both use a 10 us step.
// - Each channel holds a 7-bit peak code; threshold is min plus step times code.
// - Each buck also trips on a fixed overcurrent, whatever the peak code.
// - Thermal warning scales output duty to 75% until the warning clears.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module led_pwm_dimming_engine
  import dim_pkg::*;
#(
  parameter logic [7:0] DUTY0_DEFAULT = 8'h00, // Start-up duty code, ch 0
  parameter logic [7:0] DUTY1_DEFAULT = 8'h00, // Start-up duty code, ch 1
  parameter int THR_W = 12, // Peak threshold width
  parameter logic [THR_W-1:0] THR_MIN = 12'h020, // Threshold at code 0
  parameter logic [THR_W-1:0] THR_STEP = 12'h004 // Threshold per code step
)(
  input wire logic aclk, // System clock, 10 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [1:0] dimming_input, // Dimming PWM inputs
  input wire logic thermal_warning, // On-chip thermal warning
  input wire logic [8:0] battery_derate, // Battery derating, 256 = none
  input wire logic [1:0] overcurrent, // Fixed-threshold overcurrent trips
  output logic [1:0] buck_switch_enable, // Buck switch enables
  output logic [THR_W-1:0] peak_threshold0, // Peak comparator set point 0
  output logic [THR_W-1:0] peak_threshold1, // Peak comparator set point 1
  output logic irq // Interrupt, active high level
);
  // Sample grid strobe
  logic [TICK_W-1:0] tick_cnt;
  logic tick;

  // Software state
  logic [1:0] dim_freq_multiplier;
  logic derate_dis;
  logic [7:0] dim_duty_factor [2];
  logic [6:0] peak_code [2];
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [8:0] shared_derating_factor;
  logic thermal_d;
  logic [1:0] full_on_d;

  // Per-channel data path
  dim_meas_type meas [2];
  logic [CNT_W-1:0] src_period [2];
  logic [CNT_W-1:0] src_high [2];
  logic [CNT_W-1:0] out_period [2];
  logic [CNT_W-1:0] out_on [2];
  logic [1:0] enable;

  // The 10 us strobe paces both the samplers and the rebuilders
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_W'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == TICK_W'(TICK_CYCLES - 1)) ? '0 :
                  tick_cnt + 1'b1;
    end
  end

  // Derating: battery factor unless disabled, then 3/4 in thermal warning.
  // Registered once and shared so both channels change in the same cycle.
  wire [8:0] base_drf = derate_dis ? DRF_UNITY : battery_derate;
  wire [10:0] base_x3 = {2'h0, base_drf} + {1'b0, base_drf, 1'b0};
  wire [8:0] next_drf = thermal_warning ? base_x3[10:2] : base_drf;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_derating_factor <= DRF_UNITY;
    end else begin
      shared_derating_factor <= next_drf;
    end
  end

  wire scaling = (shared_derating_factor < DRF_UNITY);

  // Two identical channels
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      wire [7:0] keep = DUTY_FULL_CODE - dim_duty_factor[ch];
      wire [CNT_W-1:0] per_sh = src_period[ch] >> dim_freq_multiplier;
      wire [CNT_W-1:0] hi_sh = src_high[ch] >> dim_freq_multiplier;
      wire [20:0] prod = hi_sh * keep;
      // x/255 taken as (x + x/256 + 1)/256, exact to one tick
      wire [20:0] div255 = (prod + (prod >> 8) + 21'h1) >> 8;
      wire [29:0] dprod = div255 * shared_derating_factor;
      wire [29:0] on_scaled = dprod >> DRF_SHIFT;
      wire fallback = meas[ch].full_on & ((keep != DUTY_FULL_CODE) | scaling);

      dim_input_sampler u_sampler (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .dimming_input(dimming_input[ch]),
        .meas(meas[ch])
      );

      // Source period: measured input, the 500 Hz fallback timer, or off
      always_comb begin
        if (meas[ch].full_on) begin
          src_period[ch] = FALLBACK_TICKS;
          src_high[ch] = fallback ? FALLBACK_TICKS : CNT_MAX;
        end else if (meas[ch].full_off || !meas[ch].valid) begin
          src_period[ch] = FALLBACK_TICKS;
          src_high[ch] = '0;
        end else begin
          src_period[ch] = meas[ch].period;
          src_high[ch] = meas[ch].high;
        end
      end

      // Divide period by the multiplier; a zero result would stall
      assign out_period[ch] = (per_sh == '0) ? CNT_W'(1) : per_sh;
      // A code of 255 gives keep zero, so the product is zero
      assign out_on[ch] = (keep == '0) ? '0 : on_scaled[CNT_W-1:0];

      dim_pwm_rebuilder u_rebuild (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .period(out_period[ch]),
        .on_time(out_on[ch]),
        .kill(overcurrent[ch]),
        .enable(enable[ch])
      );
    end
  endgenerate

  // Enables and thresholds leave through flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buck_switch_enable <= '0;
      peak_threshold0 <= THR_MIN;
      peak_threshold1 <= THR_MIN;
    end else begin
      buck_switch_enable <= enable;
      peak_threshold0 <= THR_MIN + THR_W'(THR_STEP * peak_code[0]);
      peak_threshold1 <= THR_MIN + THR_W'(THR_STEP * peak_code[1]);
    end
  end

  // AXI4-Lite write: address and data are taken together in one cycle,
  // which keeps the decode simple at the cost of one idle cycle per write
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready &
               ~s_axi_bvalid;
  wire [7:0] wa = s_axi_awaddr;
  wire wa_ok = (wa == OFF_CTRL) | (wa == OFF_DUTY0) | (wa == OFF_DUTY1) |
               (wa == OFF_PEAK) | (wa == OFF_STATE) | (wa == OFF_IRQ_STAT) |
               (wa == OFF_IRQ_MASK);
  wire b0 = wr_go & s_axi_wstrb[0];
  wire b1 = wr_go & s_axi_wstrb[1];
  wire wr_ctrl = b0 & (wa == OFF_CTRL);
  wire wr_duty0 = b0 & (wa == OFF_DUTY0);
  wire wr_duty1 = b0 & (wa == OFF_DUTY1);
  wire wr_peak0 = b0 & (wa == OFF_PEAK);
  wire wr_peak1 = b1 & (wa == OFF_PEAK);
  wire wr_istat = b0 & (wa == OFF_IRQ_STAT);
  wire wr_imask = b0 & (wa == OFF_IRQ_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers; duty defaults stand in for the stored start values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dim_freq_multiplier <= DFF_RESET;
      derate_dis <= 1'b0;
      dim_duty_factor[0] <= DUTY0_DEFAULT;
      dim_duty_factor[1] <= DUTY1_DEFAULT;
      peak_code[0] <= PEAK_RESET;
      peak_code[1] <= PEAK_RESET;
      irq_mask <= MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        dim_freq_multiplier <= s_axi_wdata[CTRL_DFF_LSB +: 2];
        derate_dis <= s_axi_wdata[CTRL_DERATE_DIS];
      end
      if (wr_duty0) begin
        dim_duty_factor[0] <= s_axi_wdata[7:0];
      end
      if (wr_duty1) begin
        dim_duty_factor[1] <= s_axi_wdata[7:0];
      end
      if (wr_peak0) begin
        peak_code[0] <= s_axi_wdata[6:0];
      end
      if (wr_peak1) begin
        peak_code[1] <= s_axi_wdata[PEAK1_LSB +: 7];
      end
      if (wr_imask) begin
        irq_mask <= s_axi_wdata[IRQ_W-1:0];
      end
    end
  end

  // Sticky events: overcurrent trips, thermal warning onset, full-on entry.
  // A new event in the cycle of its clear wins over the clear.
  wire [1:0] full_on_now = {meas[1].full_on, meas[0].full_on};
  wire [IRQ_W-1:0] events = {
    |(full_on_now & ~full_on_d),
    thermal_warning & ~thermal_d,
    overcurrent[1],
    overcurrent[0]
  };
  wire [IRQ_W-1:0] clr = wr_istat ? s_axi_wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
      thermal_d <= 1'b0;
      full_on_d <= '0;
      irq <= 1'b0;
    end else begin
      thermal_d <= thermal_warning;
      full_on_d <= full_on_now;
      irq_stat <= (irq_stat & ~clr) | events;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // AXI4-Lite read: the address is taken and the data returned in the same cycle
  wire rd_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] state_word = {24'h0, 2'h0,
    meas[1].full_off, meas[1].full_on, meas[0].full_off, meas[0].full_on,
    buck_switch_enable};
  wire rd_ok = (ra == OFF_CTRL) | (ra == OFF_DUTY0) | (ra == OFF_DUTY1) |
               (ra == OFF_PEAK) | (ra == OFF_STATE) | (ra == OFF_IRQ_STAT) |
               (ra == OFF_IRQ_MASK);
  logic [31:0] rd_word;

  always_comb begin
    case (ra)
      OFF_CTRL: rd_word = 32'(dim_freq_multiplier) |
                          32'({derate_dis, 4'h0});
      OFF_DUTY0: rd_word = 32'(dim_duty_factor[0]);
      OFF_DUTY1: rd_word = 32'(dim_duty_factor[1]);
      OFF_PEAK: rd_word = {17'h0, peak_code[1], 1'b0, peak_code[0]};
      OFF_STATE: rd_word = state_word;
      OFF_IRQ_STAT: rd_word = 32'(irq_stat);
      OFF_IRQ_MASK: rd_word = 32'(irq_mask);
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // led_pwm_dimming_engine
`default_nettype wire

/* bench/dim_engine_checker.sv */
// Checker of the dimming engine: bus handshakes and enable timing.
// Assumes it is bound to the engine top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module dim_engine_checker (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B code
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic [1:0] overcurrent, // Trips
  input wire logic [1:0] buck_switch_enable, // Enables
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Reset must quiet the enables, irq and both response valids, so no reset exemption here
  property p_rst_quiet;
    disable iff (1'b0) !aresetn |=> buck_switch_enable == 2'h0
      && !irq && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active after reset");
  property p_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
      |=> s_axi_awready && s_axi_wready && s_axi_bvalid;
  endproperty
  a_wr_take: assert property (p_wr_take)
    else $error("write not taken in one cycle");
  property p_aw_pulse;
    s_axi_awready |-> s_axi_wready ##1 !s_axi_awready;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse)
    else $error("write ready not a joint pulse");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_rd_take;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
      |=> s_axi_arready && s_axi_rvalid;
  endproperty
  a_rd_take: assert property (p_rd_take)
    else $error("read not answered in one cycle");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  property p_oc0;
    overcurrent[0] |-> ##2 !buck_switch_enable[0];
  endproperty
  a_oc0: assert property (p_oc0)
    else $error("channel 0 enable kept through trip");
  property p_oc1;
    overcurrent[1] |-> ##2 !buck_switch_enable[1];
  endproperty
  a_oc1: assert property (p_oc1)
    else $error("channel 1 enable kept through trip");
  // Pulses come in whole 100-cycle steps, so none ends within 8 cycles
  property p_min_on;
    $rose(buck_switch_enable[0]) ##0 (!overcurrent[0])[*8]
      |=> buck_switch_enable[0];
  endproperty
  a_min_on: assert property (p_min_on)
    else $error("enable pulse shorter than one step");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(irq));
endmodule // dim_engine_checker
`default_nettype wire

/* bench/dim_pwm_source.sv */
// Behavioural PWM source in place of the outside dimming controller.
// Assumes period and high time come in ticks of 100 clock cycles.
`timescale 1ns/10ps
`default_nettype none
module dim_pwm_source (
  input wire logic aclk, // Clock
  input wire logic [12:0] period, // Period, ticks
  input wire logic [12:0] high, // High time, ticks
  output logic pwm // Dimming level
);
  int cnt = 0;
  int len = 100;
  int hot = 0;
  initial pwm = 1'b0;
  // New settings wait for the wrap so no input pulse is cut short
  always @(posedge aclk) begin
    if (cnt + 1 >= len) begin
      cnt <= 0;
      len <= period * 100;
      hot <= high * 100;
    end else begin
      cnt <= cnt + 1;
    end
    pwm <= (cnt < hot);
  end
endmodule // dim_pwm_source
`default_nettype wire

/* bench/tb_led_pwm_dimming_engine.sv */
// Self-checking bench of the dimming engine through its register bus.
// Assumes two behavioural PWM sources drive the dimming inputs.
`timescale 1ns/10ps
`default_nettype none
module tb_led_pwm_dimming_engine
  import dim_pkg::*;
;
  localparam logic [11:0] T_MIN = 12'h020;
  localparam logic [11:0] T_STEP = 12'h004;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, thermal_warning, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, overcurrent, buck_switch_enable;
  logic [8:0] battery_derate;
  logic [11:0] peak_threshold0, peak_threshold1;
  logic [12:0] per0, hi0, per1, hi1;
  wire logic [1:0] dimming_input;
  int num_errors = 0;
  int tests_run = 0;

  dim_pwm_source i_src0 (.aclk, .period(per0), .high(hi0),
    .pwm(dimming_input[0]));
  dim_pwm_source i_src1 (.aclk, .period(per1), .high(hi1),
    .pwm(dimming_input[1]));
  led_pwm_dimming_engine #(.THR_MIN(T_MIN), .THR_STEP(T_STEP)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .dimming_input, .thermal_warning,
    .battery_derate, .overcurrent, .buck_switch_enable, .peak_threshold0,
    .peak_threshold1, .irq);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  // The divide by 255 may land one step low, so allow one step
  function automatic int near(input int s, input int e);
    return (s >= e - 1 && s <= e + 1) ? e : s;
  endfunction

  task automatic conclude();
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Response ready is raised only after the take, so holds get exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, ed);
    check(32'(s_axi_rresp), 32'(er));
  endtask

  // Measures one whole output period, on time and period in ticks
  task automatic pwm(input int ch, input int eon, input int eper);
    int c;
    c = 0;
    @(posedge aclk);
    while (buck_switch_enable[ch] !== 1'b0) @(posedge aclk);
    while (buck_switch_enable[ch] !== 1'b1) @(posedge aclk);
    while (buck_switch_enable[ch] === 1'b1) begin
      @(posedge aclk);
      c++;
    end
    check(32'(near((c + 50) / 100, eon)), 32'(eon));
    while (buck_switch_enable[ch] !== 1'b1) begin
      @(posedge aclk);
      c++;
    end
    check(32'((c + 50) / 100), 32'(eper));
  endtask

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Whole run is about 70000 cycles
  initial begin
    repeat (90000) @(posedge aclk);
    num_errors++;
    conclude();
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, thermal_warning} = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    overcurrent = 2'h0;
    battery_derate = 9'h100;
    {per0, per1} = {13'h0020, 13'h0020};
    {hi0, hi1} = {13'h0010, 13'h0010};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    check(32'(buck_switch_enable), 32'h0);
    check(32'(peak_threshold0), 32'(T_MIN));
    rd(OFF_DUTY0, 32'h0, RESP_OKAY);
    wr(OFF_PEAK, 32'h7f05, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'(peak_threshold0), 32'(T_MIN) + 32'h5 * T_STEP);
    check(32'(peak_threshold1), 32'(T_MIN) + 32'h7f * T_STEP);
    wr(8'h1c, 32'hff, RESP_SLVERR);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    wr(OFF_DUTY1, 32'h33, RESP_OKAY);
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    rd(OFF_DUTY1, 32'h33, RESP_OKAY);
    repeat (14000) @(posedge aclk);
    pwm(0, 8, 16);
    pwm(1, 6, 16);
    wr(OFF_DUTY0, 32'hff, RESP_OKAY);
    repeat (3200) @(posedge aclk);
    pwm(1, 6, 16);
    check(32'(buck_switch_enable[0]), 32'h0);
    wr(OFF_DUTY0, 32'h0, RESP_OKAY);
    thermal_warning <= 1'b1;
    repeat (3200) @(posedge aclk);
    pwm(0, 6, 16);
    thermal_warning <= 1'b0;
    battery_derate <= 9'h080;
    repeat (3200) @(posedge aclk);
    pwm(0, 4, 16);
    pwm(1, 3, 16);
    wr(OFF_CTRL, 32'h11, RESP_OKAY);
    repeat (3200) @(posedge aclk);
    pwm(0, 8, 16);
    battery_derate <= 9'h100;
    hi0 <= 13'h0018;
    repeat (8000) @(posedge aclk);
    pwm(0, 12, 16);
    per0 <= 13'h0018;
    hi0 <= 13'h000c;
    repeat (14000) @(posedge aclk);
    pwm(0, 6, 12);
    check(32'(irq), 32'h0);
    wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
    while (buck_switch_enable[0] !== 1'b1) @(posedge aclk);
    overcurrent <= 2'h3;
    @(posedge aclk);
    overcurrent <= 2'h0;
    repeat (3) @(posedge aclk);
    check(32'(buck_switch_enable[0]), 32'h0);
    check(32'(irq), 32'h1);
    rd(OFF_IRQ_STAT, 32'h7, RESP_OKAY);
    wr(OFF_IRQ_STAT, 32'h7, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0);
    rd(OFF_IRQ_STAT, 32'h0, RESP_OKAY);
    conclude();
  end
endmodule // tb_led_pwm_dimming_engine

bind led_pwm_dimming_engine dim_engine_checker i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .overcurrent, .buck_switch_enable, .irq);
`default_nettype wire
